// ===== core/uarx_core.sv
// Purpose: Start-bit clock recovery and majority-vote data recovery of a serial receiver.
// Assumes: sample_tick is a one-cycle pulse at 16 or 8 times the bit rate.
// Notes: One received frame is held for software with its frame error flag.
// Functional notes
// - Sample the line sixteen ticks per bit, or eight in double speed.
// - Double speed applies when the double speed select bit is one.
// - Idle falling edge starts start detection; first low sample is sample one.
// - Start validity uses samples 8, 9, 10, or 4, 5, 6 in double speed.
// - Two or more high start samples reject the start as noise.
// - Bit timing resynchronises on each valid start; data follows only then.
// - Each start and data bit walks sixteen (or eight) sample states, numbered by state.
// - Each data and parity bit is the majority of three centre samples.
// - Recovery runs through the first stop bit; later stop bits are ignored.
// - Stop bit is voted; a zero sets the frame error flag.
// - Next falling edge accepted right after the stop vote; later in double speed.
// - Frames carry five to ten data plus parity bits.
// - Frame error is held with its frame until that frame is read.
// - Clearing the receiver enable stops reception and flushes the held frame.
//
// The implementer's own choices: the APB register port and the register offsets.
`default_nettype none
module uarx_core
  import uarx_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line and oversampling tick.
  input wire logic serial_in_pin,
  input wire logic sample_tick,
  // Interrupt.
  output logic irq
);
  logic sync1_r;
  logic sync2_r;
  logic last_r;
  logic [7:0] ctrl_r;
  logic [NUM_EV-1:0] stat_r;
  logic [NUM_EV-1:0] ien_r;
  logic [31:0] prdata_r;
  uarx_state_t state_r;
  uarx_state_t state_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;
  logic [1:0] hist_r;
  logic [9:0] shreg_r;
  uarx_frame_t hold_r;
  logic full_r;

  // Register decode.
  wire access = psel & penable;
  wire setup = psel & ~penable;
  wire wr = access & pwrite;
  wire hit_ctrl = paddr == UARX_CTRL_OFS;
  wire hit_data = paddr == UARX_DATA_OFS;
  wire hit_stat = paddr == UARX_STAT_OFS;
  wire hit_clr = paddr == UARX_CLR_OFS;
  wire hit_ien = paddr == UARX_IEN_OFS;
  wire hit = hit_ctrl | hit_data | hit_stat | hit_clr | hit_ien;
  // Popping only a frame that was captured at setup keeps a frame that lands
  // during the access phase from being discarded unseen.
  wire pop = access & ~pwrite & hit_data & prdata_r[DATA_VALID_BIT];

  // Mode decode.
  wire en = ctrl_r[CTRL_EN_BIT];
  wire ds = ctrl_r[CTRL_DS_BIT];
  wire [3:0] len_cfg = ctrl_r[CTRL_LEN_LSB +: 4];
  wire [3:0] len = (len_cfg < LEN_MIN) ? LEN_MIN : (len_cfg > LEN_MAX) ? LEN_MAX : len_cfg;
  wire [4:0] spb = ds ? SPB_DOUBLE : SPB_NORMAL;
  wire [4:0] vote_first = ds ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
  wire [4:0] vote_pos = vote_first + 5'h02;
  wire [4:0] stop_exit = ds ? vote_pos + 5'h01 : vote_pos;

  // Sampling decode; line is read only after the second synchroniser stage.
  wire line = sync2_r;
  wire tick = sample_tick & en;
  wire busy = state_r != ST_IDLE;
  wire fall = tick & last_r & ~line;
  wire at_capture = tick & busy & ((cnt_r == vote_first) | (cnt_r == vote_first + 5'h01));
  wire at_vote = tick & busy & (cnt_r == vote_pos);
  wire at_end = tick & busy & (cnt_r == spb);
  wire maj = (hist_r[1] & hist_r[0]) | (hist_r[1] & line) | (hist_r[0] & line);
  wire frame_done = at_vote & (state_r == ST_STOP);
  wire [NUM_EV-1:0] ev;
  assign ev[EV_DONE] = frame_done;
  assign ev[EV_FE] = frame_done & ~maj;
  assign ev[EV_OVR] = frame_done & full_r & ~pop;
  wire [NUM_EV-1:0] clr_mask = (wr & hit_clr) ? pwdata[NUM_EV-1:0] : '0;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    if (tick & busy)
    begin
      cnt_nxt = at_end ? 5'h01 : cnt_r + 5'h01;
    end
    case (state_r)
      ST_IDLE:
      begin
        if (fall)
        begin
          state_nxt = ST_START;
          // The edge tick is sample one, so the next tick must count as two.
          cnt_nxt = 5'h02;
        end
      end
      ST_START:
      begin
        if (at_vote & maj)
        begin
          state_nxt = ST_IDLE;
        end
        else if (at_end)
        begin
          state_nxt = ST_DATA;
          idx_nxt = 4'h0;
        end
      end
      ST_DATA:
      begin
        if (at_end)
        begin
          if (idx_r == len - 4'h1)
          begin
            state_nxt = ST_STOP;
          end
          else
          begin
            idx_nxt = idx_r + 4'h1;
          end
        end
      end
      ST_STOP:
      begin
        if (tick & (cnt_r == stop_exit))
        begin
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (!en)
    begin
      state_nxt = ST_IDLE;
    end
  end

  // Two-stage input synchroniser.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end
    else
    begin
      sync1_r <= serial_in_pin;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
      idx_r <= 4'h0;
      last_r <= 1'b1;
      hist_r <= 2'h0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      if (tick)
      begin
        last_r <= line;
      end
      if (at_capture)
      begin
        hist_r <= {hist_r[0], line};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shreg_r <= 10'h000;
    end
    else if (state_r == ST_IDLE)
    begin
      shreg_r <= 10'h000;
    end
    else if (at_vote & (state_r == ST_DATA))
    begin
      shreg_r[idx_r] <= maj;
    end
  end

  // Single holding slot; the error flag travels with its frame.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      full_r <= 1'b0;
      hold_r <= '0;
    end
    else if (!en)
    begin
      full_r <= 1'b0;
    end
    else if (frame_done & (~full_r | pop))
    begin
      full_r <= 1'b1;
      hold_r <= '{fe: ~maj, data: shreg_r};
    end
    else if (pop)
    begin
      full_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= CTRL_RST;
      ien_r <= IEN_RST;
      stat_r <= '0;
    end
    else
    begin
      if (wr & hit_ctrl)
      begin
        ctrl_r <= pwdata[7:0];
      end
      if (wr & hit_ien)
      begin
        ien_r <= pwdata[NUM_EV-1:0];
      end
      stat_r <= (stat_r & ~clr_mask) | ev;
    end
  end

  // Read data is captured in the setup cycle so the access phase needs no wait.
  wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_r} :
                       hit_data ? {full_r, 14'h0000, hold_r.fe, 6'h00, hold_r.data} :
                       hit_stat ? {22'h000000, full_r, busy, 5'h00, stat_r} :
                       hit_ien ? {29'h00000000, ien_r} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h00000000;
    end
    else if (setup & ~pwrite)
    begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign irq = |(stat_r & ien_r);

  sync_chain_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 (line == $past(serial_in_pin, 2))) else $error("synchroniser depth wrong");
  start_detect_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_IDLE && fall) |=> (state_r == ST_START && cnt_r == 5'h02))
    else $error("falling edge not taken as sample one");
  start_reject_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_START && at_vote && maj) |=> state_r == ST_IDLE)
    else $error("noisy start not rejected");
  start_accept_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_START && at_end && en) |=> (state_r == ST_DATA && idx_r == 4'h0))
    else $error("valid start did not begin data");
  bit_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && en && cnt_r <= spb) |-> cnt_r != 5'h00) else $error("sample state out of range");
  double_span_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_DATA && ds) |-> cnt_r <= SPB_DOUBLE) else $error("double speed span exceeded");
  vote_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_DATA && at_vote && en) |=> shreg_r[$past(idx_r)] == $past(maj))
    else $error("voted bit not stored");
  frame_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_DATA && state_nxt == ST_STOP) |-> idx_r == len - 4'h1)
    else $error("wrong number of bits before stop");
  stop_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_done && !full_r && en) |=> (full_r && hold_r.fe == !$past(maj)))
    else $error("frame error not held with frame");
  stop_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_STOP && tick && cnt_r == stop_exit) |=> state_r == ST_IDLE)
    else $error("receiver not rearmed after stop");
  disable_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
    !en |=> (state_r == ST_IDLE && !full_r)) else $error("disable did not flush");
  // The vote checks name sample numbers outright so that an off-by-one count shows up.
  start_window_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_START && state_nxt == ST_IDLE && en) |-> cnt_r == (ds ? 5'h06 : 5'h0A))
    else $error("start decided off its third vote sample");
  // A held frame may only leave by a read or a disable.
  hold_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (full_r && !pop && en) |=> (full_r && $stable(hold_r)))
    else $error("held frame changed before it was read");
  pop_empty_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pop && !frame_done) |=> !full_r)
    else $error("read frame not released");
  // A same-cycle clear must not hide the event; the set wins.
  stop_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev[EV_FE] |=> stat_r[EV_FE])
    else $error("frame error event lost");
  frame_seen_c: cover property (@(posedge pclk) disable iff (!presetn) frame_done && maj);
  noise_reject_c: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_START && at_vote && maj);
  frame_error_c: cover property (@(posedge pclk) disable iff (!presetn) ev[EV_FE]);
  overrun_c: cover property (@(posedge pclk) disable iff (!presetn) ev[EV_OVR]);
  double_frame_c: cover property (@(posedge pclk) disable iff (!presetn)
    frame_done && ds);
endmodule : uarx_core
`default_nettype wire

// ===== core/uarx_pkg.sv
// Purpose: Shared constants and types of the asynchronous receive recovery block.
// Assumes: APB register map with one aligned 32-bit word per register.
// Notes: Offsets are byte addresses.
`default_nettype none
package uarx_pkg;
  localparam logic [7:0] UARX_CTRL_OFS = 8'h00;
  localparam logic [7:0] UARX_DATA_OFS = 8'h04;
  localparam logic [7:0] UARX_STAT_OFS = 8'h08;
  localparam logic [7:0] UARX_CLR_OFS = 8'h0C;
  localparam logic [7:0] UARX_IEN_OFS = 8'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DS_BIT = 1;
  localparam int CTRL_LEN_LSB = 4;
  localparam logic [7:0] CTRL_RST = 8'h80;
  localparam logic [2:0] IEN_RST = 3'h0;
  localparam int DATA_FE_BIT = 16;
  localparam int DATA_VALID_BIT = 31;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_FULL_BIT = 9;
  localparam int NUM_EV = 3;
  localparam int EV_DONE = 0;
  localparam int EV_FE = 1;
  localparam int EV_OVR = 2;
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [3:0] LEN_MIN = 4'h5;
  localparam logic [3:0] LEN_MAX = 4'hA;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b11,
    ST_STOP = 2'b10
  } uarx_state_t;
  typedef struct packed {
    logic fe;
    logic [9:0] data;
  } uarx_frame_t;
endpackage : uarx_pkg
`default_nettype wire

// ===== testbench/tb.sv
// Purpose: Self-checking bench of the receive recovery block over APB.
// Assumes: Sample tick every fourth clock; zero wait APB slave.
// Notes: A glitch source overlays the line to build noise and start edges.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import uarx_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, busy, tx_line, err;
  logic sample_tick = 1'b0;
  logic go = 1'b0;
  logic noise = 1'b0;
  logic [11:0] frame = 12'hFFF;
  logic [3:0] nbits = 4'h8;
  logic [4:0] spb = SPB_NORMAL;
  logic [1:0] div_r = 2'h0;
  logic [31:0] rv;
  logic [3:0] len;
  logic [9:0] d;
  int num_errors = 0;
  int checks = 0;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    div_r <= div_r + 2'h1;
    sample_tick <= (div_r == 2'h3);
  end
  uarx_core u_uarx_core (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(tx_line & ~noise), .sample_tick(sample_tick),
    .irq(irq));
  uarx_tx_model u_uarx_tx_model (.pclk(pclk), .presetn(presetn), .sample_tick(sample_tick),
    .go(go), .frame(frame), .nbits(nbits), .spb(spb), .busy(busy), .line(tx_line));
  task automatic end_sim;
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      chk(32'h0, 32'h1);
      end_sim;
    end
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv & mk, exp);
  endtask : rd
  task automatic irq_is(input logic exp);
    @(posedge pclk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask : irq_is
  task automatic launch(input logic [9:0] dv, input logic [3:0] n, input logic stop);
    logic [11:0] w;
    w = 12'hFFE;
    for (int k = 0; k < n; k++)
      w[k + 1] = dv[k];
    w[n + 1] = stop;
    @(posedge pclk);
    frame <= w;
    nbits <= n;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
  endtask : launch
  task automatic waitdone;
    int k;
    k = 0;
    // The model raises busy one edge after go, so look only after an edge.
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (busy !== 1'b0 && k < 3000);
    if (busy !== 1'b0)
    begin
      chk(32'h0, 32'h1);
      end_sim;
    end
    repeat (4) @(posedge pclk);
  endtask : waitdone
  task automatic send(input logic [9:0] dv, input logic [3:0] n, input logic stop);
    launch(dv, n, stop);
    waitdone;
  endtask : send
  // A low pulse of t ticks; exp is the data word then expected, an old held word if rejected.
  task automatic glitch(input int t, input logic [31:0] exp);
    noise <= 1'b1;
    repeat (t * 4) @(posedge pclk);
    noise <= 1'b0;
    repeat (900) @(posedge pclk);
    rd(UARX_DATA_OFS, 32'h800003FF, exp);
    apb(1'b1, UARX_CLR_OFS, 32'h7);
  endtask : glitch
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(UARX_CTRL_OFS, 32'hFF, {24'h0, CTRL_RST});
    rd(UARX_IEN_OFS, 32'h7, 32'h0);
    rd(UARX_STAT_OFS, 32'h307, 32'h0);
    rd(8'h14, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, UARX_IEN_OFS, 32'h7);
    for (int m = 0; m < 2; m++)
    begin
      spb <= m ? SPB_DOUBLE : SPB_NORMAL;
      for (int j = 0; j < 3; j++)
      begin
        len = (j == 0) ? LEN_MIN : (j == 1) ? 4'h8 : LEN_MAX;
        d = (m ? 10'h35A : 10'h2A5) & ((10'h1 << len) - 10'h1);
        apb(1'b1, UARX_CTRL_OFS, {24'h0, len, 2'b00, m[0], 1'b1});
        send(d, len, 1'b1);
        irq_is(1'b1);
        rd(UARX_STAT_OFS, 32'h307, 32'h201);
        rd(UARX_DATA_OFS, 32'hFFFFFFFF, {1'b1, 14'h0, 1'b0, 6'h0, d});
        rd(UARX_DATA_OFS, 32'h80000000, 32'h0);
        apb(1'b1, UARX_CLR_OFS, 32'h7);
        irq_is(1'b0);
      end
      glitch(m ? 4 : 8, {22'h0, d});
      glitch(m ? 5 : 9, 32'h800003FF);
    end
    spb <= SPB_NORMAL;
    apb(1'b1, UARX_CTRL_OFS, 32'h21);
    send(10'h015, 4'h5, 1'b1);
    rd(UARX_DATA_OFS, 32'hFFFFFFFF, 32'h80000015);
    apb(1'b1, UARX_CLR_OFS, 32'h7);
    apb(1'b1, UARX_CTRL_OFS, 32'h81);
    spb <= SPB_NORMAL;
    send(10'h03C, 4'h8, 1'b0);
    rd(UARX_STAT_OFS, 32'h307, 32'h203);
    rd(UARX_DATA_OFS, 32'hFFFFFFFF, 32'h8001003C);
    apb(1'b1, UARX_CLR_OFS, 32'h7);
    apb(1'b1, UARX_IEN_OFS, 32'h0);
    send(10'h055, 4'h8, 1'b1);
    irq_is(1'b0);
    apb(1'b1, UARX_IEN_OFS, 32'h7);
    irq_is(1'b1);
    send(10'h0AA, 4'h8, 1'b1);
    rd(UARX_STAT_OFS, 32'h205, 32'h205);
    launch(10'h0F0, 4'h8, 1'b1);
    repeat (300) @(posedge pclk);
    rd(UARX_STAT_OFS, 32'h100, 32'h100);
    apb(1'b1, UARX_CTRL_OFS, 32'h80);
    rd(UARX_STAT_OFS, 32'h300, 32'h0);
    waitdone;
    apb(1'b1, UARX_CTRL_OFS, 32'h81);
    rd(UARX_DATA_OFS, 32'h80000000, 32'h0);
    apb(1'b1, UARX_CLR_OFS, 32'h7);
    rd(UARX_STAT_OFS, 32'h7, 32'h0);
    irq_is(1'b0);
    end_sim;
  end
endmodule : tb
`default_nettype wire

// ===== testbench/uarx_tx_model.sv
// Purpose: Remote asynchronous transmitter that drives the receive line.
// Assumes: One sample_tick is one oversampling period of the receiver.
// Notes: Frame word holds start, bits and stop, sent from bit 0 up.
`default_nettype none
module uarx_tx_model
(
  // Clock, reset and tick.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_tick,
  // Frame request.
  input wire logic go,
  input wire logic [11:0] frame,
  input wire logic [3:0] nbits,
  input wire logic [4:0] spb,
  // Line.
  output logic busy,
  output logic line
);
  logic [11:0] sh_r;
  logic [4:0] tk_r;
  logic [3:0] left_r;
  // Outside a frame the line idles high, as its pull-up would hold it.
  assign line = busy ? sh_r[0] : 1'b1;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy <= 1'b0;
    else if (go)
    begin
      sh_r <= frame;
      tk_r <= 5'h00;
      left_r <= nbits + 4'h2;
      busy <= 1'b1;
    end
    // Bit time equals the receiver's, so the rate error stays inside its share.
    else if (busy && sample_tick && tk_r == spb - 5'h01)
    begin
      tk_r <= 5'h00;
      sh_r <= {1'b1, sh_r[11:1]};
      left_r <= left_r - 4'h1;
      busy <= (left_r != 4'h1);
    end
    else if (busy && sample_tick)
      tk_r <= tk_r + 5'h01;
  end
endmodule : uarx_tx_model
`default_nettype wire
